// ===== verilog/gpx_pkg.sv
// constants, register map and carriers of the eight-pin port block
// assumes an APB master with 32-bit data and byte addresses on PADDR
// Functional notes
// - eight pins 0..7, all logic per pin
// - inverted input reads as complement in input register
// - inverted output drives complement of output register
// - inversion also applies to alternate function signals
// - keeper pulls toward last seen pin level
// - sense both, rising, falling edges or low level
// - synchronous sensing with clock, asynchronous without
// - sensing evaluates the inverted pin value
// - two interrupt requests, own level each
// - per-pin source mask for each interrupt
// - masked pin meeting its sense raises interrupt
// - every sense mode can wake without port clock
// - set, clear, toggle addresses for output, direction
// - event channel 0 optionally overrides pin 7
// - selectable totem, pull, keeper, wired-and, wired-or drivers
// - direction selectable per pin
// - one write configures several pins at once
// - bit-addressable view of data, direction, input, flags
// - optional half-rate system clock output on one pin
// - interrupt level high, medium or low reported
// - alternate function replaces general purpose output path
package gpx_pkg;
  localparam int NPIN = 8;
  localparam logic [7:0] OFS_DIR      = 8'h00;
  localparam logic [7:0] OFS_DIRSET   = 8'h04;
  localparam logic [7:0] OFS_DIRCLR   = 8'h08;
  localparam logic [7:0] OFS_DIRTGL   = 8'h0c;
  localparam logic [7:0] OFS_OUT      = 8'h10;
  localparam logic [7:0] OFS_OUTSET   = 8'h14;
  localparam logic [7:0] OFS_OUTCLR   = 8'h18;
  localparam logic [7:0] OFS_OUTTGL   = 8'h1c;
  localparam logic [7:0] OFS_IN       = 8'h20;
  localparam logic [7:0] OFS_INTCTRL  = 8'h24;
  localparam logic [7:0] OFS_INT0MASK = 8'h28;
  localparam logic [7:0] OFS_INT1MASK = 8'h2c;
  localparam logic [7:0] OFS_INTFLAGS = 8'h30;
  localparam logic [7:0] OFS_MPCMASK  = 8'h34;
  localparam logic [7:0] OFS_ALTCTRL  = 8'h38;
  localparam logic [7:0] OFS_PINCFG0  = 8'h40;
  localparam logic [7:0] OFS_BITWIN   = 8'h80;
  // bit window register selects
  localparam logic [1:0] BW_DIR   = 2'h0;
  localparam logic [1:0] BW_OUT   = 2'h1;
  localparam logic [1:0] BW_IN    = 2'h2;
  localparam logic [1:0] BW_FLAGS = 2'h3;
  // sense selects
  localparam logic [1:0] ISC_BOTH = 2'h0;
  localparam logic [1:0] ISC_RISE = 2'h1;
  localparam logic [1:0] ISC_FALL = 2'h2;
  localparam logic [1:0] ISC_LOW  = 2'h3;
  // driver selects
  localparam logic [2:0] OPC_TOTEM  = 3'h0;
  localparam logic [2:0] OPC_KEEPER = 3'h1;
  localparam logic [2:0] OPC_PULLDN = 3'h2;
  localparam logic [2:0] OPC_PULLUP = 3'h3;
  localparam logic [2:0] OPC_WOR    = 3'h4;
  localparam logic [2:0] OPC_WAND   = 3'h5;
  localparam logic [2:0] OPC_WORPD  = 3'h6;
  localparam logic [2:0] OPC_WANDPU = 3'h7;
  // interrupt levels
  localparam logic [1:0] LVL_OFF = 2'h0;
  // reset values, alternate control bit positions and event pin
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int ALT_CLKEN_BIT = 0;
  localparam int ALT_EVEN_BIT  = 4;
  localparam int EVT_PIN       = 7;

  typedef struct packed {
    logic       inv;
    logic [1:0] isc;
    logic [2:0] opc;
  } gpx_pincfg_t;

  localparam gpx_pincfg_t RST_PINCFG = '{inv: 1'b0, isc: ISC_BOTH, opc: OPC_TOTEM};

  typedef struct packed {
    logic       evt_en;
    logic [2:0] clk_pin;
    logic       clk_en;
  } gpx_altctrl_t;
endpackage

// ===== verilog/gpx_sense.sv
// per-pin input sensing: synchroniser, edge/level detect, wake path
// assumes pin_v already carries any inversion
`timescale 1ns/1ps
module gpx_sense
  import gpx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       pin_v,
  input  wire logic [1:0] isc,
  output logic            lvl_v,
  output logic            hit,
  output logic            wake
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic a_r;
  wire  rise_s = s2_r & ~s3_r;
  wire  fall_s = ~s2_r & s3_r;
  wire  rise_a = pin_v & ~a_r;
  wire  fall_a = ~pin_v & a_r;
  logic sel_s;
  logic sel_a;

  always_comb begin
    case (isc)
      ISC_BOTH: begin sel_s = rise_s | fall_s; sel_a = rise_a | fall_a; end
      ISC_RISE: begin sel_s = rise_s;          sel_a = rise_a;          end
      ISC_FALL: begin sel_s = fall_s;          sel_a = fall_a;          end
      default:  begin sel_s = ~s2_r;           sel_a = ~pin_v;          end
    endcase
  end

  // sync path frozen with the port clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pin_v;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // wake path runs while the port clock is off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      a_r <= 1'b0;
    end else begin
      a_r <= pin_v;
    end
  end

  assign lvl_v = s2_r;
  assign hit   = ce & sel_s;
  assign wake  = ~ce & sel_a;
endmodule

// ===== verilog/gpx_port.sv
// eight-pin general purpose port with sensing, two interrupts, APB access
// assumes APB slave timing: answer one cycle into the access phase
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module gpx_port
  import gpx_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST_B,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [7:0]  PIN_IN,
  output logic      [7:0]  PIN_OUT,
  output logic      [7:0]  PIN_OE_B,
  output logic      [7:0]  PIN_PULL_EN,
  output logic      [7:0]  PIN_PULL_UP,
  input  wire logic [7:0]  ALT_EN,
  input  wire logic [7:0]  ALT_OUT,
  input  wire logic [7:0]  ALT_OE,
  output logic      [7:0]  ALT_IN,
  input  wire logic        EVT_CH0,
  output logic      [7:0]  EVT_SENSE,
  output logic             INT0_REQ,
  output logic             INT1_REQ,
  output logic      [1:0]  INT0_LVL,
  output logic      [1:0]  INT1_LVL,
  output logic             WAKE
);
  logic         [7:0]  dir_r;
  logic         [7:0]  out_r;
  logic         [3:0]  intctrl_r;
  logic         [7:0]  mask0_r;
  logic         [7:0]  mask1_r;
  logic         [1:0]  flag_r;
  logic         [1:0]  flag_nxt;
  logic         [7:0]  mpc_r;
  gpx_altctrl_t        alt_r;
  gpx_pincfg_t         cfg_r [NPIN];
  logic                clkdiv_r;
  logic                ready_r;
  logic         [31:0] rdata_r;
  logic                err_r;
  logic         [7:0]  pout_r;
  logic         [7:0]  poe_b_r;
  logic         [7:0]  pull_en_r;
  logic         [7:0]  pull_up_r;
  logic         [7:0]  keep_r;
  logic         [7:0]  altin_r;
  logic         [7:0]  evt_r;
  logic                req0_r;
  logic                req1_r;
  logic                wake_r;

  logic [7:0] lvl_v;
  logic [7:0] hit;
  logic [7:0] wk;
  logic [7:0] in_val;
  logic [7:0] low_lvl;
  logic [7:0] drv_val;
  logic [7:0] drv_en;

  // bus phases
  wire acc    = PSEL & PENABLE;
  wire rd_smp = acc & ~ready_r;
  wire wr_go  = acc & ready_r & PWRITE;
  wire [7:0] wb = PWDATA[7:0];

  // address decode
  wire a_dir    = PADDR == OFS_DIR;
  wire a_dirset = PADDR == OFS_DIRSET;
  wire a_dirclr = PADDR == OFS_DIRCLR;
  wire a_dirtgl = PADDR == OFS_DIRTGL;
  wire a_out    = PADDR == OFS_OUT;
  wire a_outset = PADDR == OFS_OUTSET;
  wire a_outclr = PADDR == OFS_OUTCLR;
  wire a_outtgl = PADDR == OFS_OUTTGL;
  wire a_in     = PADDR == OFS_IN;
  wire a_ictl   = PADDR == OFS_INTCTRL;
  wire a_m0     = PADDR == OFS_INT0MASK;
  wire a_m1     = PADDR == OFS_INT1MASK;
  wire a_flg    = PADDR == OFS_INTFLAGS;
  wire a_mpc    = PADDR == OFS_MPCMASK;
  wire a_alt    = PADDR == OFS_ALTCTRL;
  wire a_cfg    = PADDR[7:5] == OFS_PINCFG0[7:5];
  wire a_bw     = PADDR[7] == OFS_BITWIN[7];
  wire [2:0] cfg_idx = PADDR[4:2];
  wire [1:0] bw_reg  = PADDR[6:5];
  wire [2:0] bw_bit  = PADDR[4:2];
  wire a_dirgrp = a_dir | a_dirset | a_dirclr | a_dirtgl;
  wire a_outgrp = a_out | a_outset | a_outclr | a_outtgl;
  wire mapped   = a_dirgrp | a_outgrp | a_in | a_ictl | a_m0 | a_m1 | a_flg
                  | a_mpc | a_alt | a_cfg | a_bw;
  wire bad      = ~mapped | (PADDR[1:0] != 2'h0);
  wire [7:0] bw_sel = 8'h01 << bw_bit;
  wire bw_wr        = wr_go & a_bw & ~bad;
  wire bw_one       = PWDATA[0];

  // single-bit access on dir, out, flags
  wire [7:0] bw_dir_s = (bw_wr && bw_reg == BW_DIR && bw_one) ? bw_sel : 8'h00;
  wire [7:0] bw_dir_c = (bw_wr && bw_reg == BW_DIR && !bw_one) ? bw_sel : 8'h00;
  wire [7:0] bw_out_s = (bw_wr && bw_reg == BW_OUT && bw_one) ? bw_sel : 8'h00;
  wire [7:0] bw_out_c = (bw_wr && bw_reg == BW_OUT && !bw_one) ? bw_sel : 8'h00;
  wire [1:0] bw_flg_c = (bw_wr && bw_reg == BW_FLAGS && bw_one) ? bw_sel[1:0] : 2'h0;

  // set, clear and toggle strobes
  wire [7:0] dir_nxt = ((((wr_go & a_dir) ? wb : dir_r)
                        | ((wr_go & a_dirset) ? wb : 8'h00) | bw_dir_s)
                        & ~(((wr_go & a_dirclr) ? wb : 8'h00) | bw_dir_c))
                        ^ ((wr_go & a_dirtgl) ? wb : 8'h00);
  wire [7:0] out_nxt = ((((wr_go & a_out) ? wb : out_r)
                        | ((wr_go & a_outset) ? wb : 8'h00) | bw_out_s)
                        & ~(((wr_go & a_outclr) ? wb : 8'h00) | bw_out_c))
                        ^ ((wr_go & a_outtgl) ? wb : 8'h00);

  // flags: hardware set wins over software clear
  wire [7:0] hit0 = hit & mask0_r;
  wire [7:0] hit1 = hit & mask1_r;
  wire [1:0] set_f = {|hit1, |hit0};
  wire [1:0] clr_f = ((wr_go & a_flg) ? PWDATA[1:0] : 2'h0) | bw_flg_c;
  assign flag_nxt = (flag_r & ~clr_f) | set_f;

  wire [1:0] lvl0 = intctrl_r[1:0];
  wire [1:0] lvl1 = intctrl_r[3:2];
  wire req0_nxt = (lvl0 != LVL_OFF) & (flag_nxt[0] | |(low_lvl & mask0_r));
  wire req1_nxt = (lvl1 != LVL_OFF) & (flag_nxt[1] | |(low_lvl & mask1_r));

  // read mux
  logic [31:0] rd_mux;
  logic [7:0]  bw_vec;
  always_comb begin
    rd_mux = RST_WORD;
    case (bw_reg)
      BW_DIR:  bw_vec = dir_r;
      BW_OUT:  bw_vec = out_r;
      BW_IN:   bw_vec = in_val;
      default: bw_vec = {6'h00, flag_r};
    endcase
    if (a_dirgrp) begin
      rd_mux[7:0] = dir_r;
    end else if (a_outgrp) begin
      rd_mux[7:0] = out_r;
    end else if (a_in) begin
      rd_mux[7:0] = in_val;
    end else if (a_ictl) begin
      rd_mux[3:0] = intctrl_r;
    end else if (a_m0) begin
      rd_mux[7:0] = mask0_r;
    end else if (a_m1) begin
      rd_mux[7:0] = mask1_r;
    end else if (a_flg) begin
      rd_mux[1:0] = flag_r;
    end else if (a_mpc) begin
      rd_mux[7:0] = mpc_r;
    end else if (a_alt) begin
      rd_mux[4:0] = alt_r;
    end else if (a_cfg) begin
      rd_mux[5:0] = cfg_r[cfg_idx];
    end else if (a_bw) begin
      rd_mux[0] = bw_vec[bw_bit];
    end
  end

  // per-pin datapath
  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      wire inv   = cfg_r[i].inv;
      wire [2:0] opc = cfg_r[i].opc;
      wire use_clk = alt_r.clk_en && (alt_r.clk_pin == 3'(i));
      wire use_evt = alt_r.evt_en && (i == EVT_PIN);
      wire src_gp  = use_evt ? EVT_CH0 : (use_clk ? clkdiv_r : out_r[i]);
      wire src     = ALT_EN[i] ? ALT_OUT[i] : src_gp;
      wire en      = ALT_EN[i] ? ALT_OE[i] : (dir_r[i] | use_clk | use_evt);
      wire v       = src ^ inv;
      wire wand_m  = (opc == OPC_WAND) || (opc == OPC_WANDPU);
      wire wor_m   = (opc == OPC_WOR) || (opc == OPC_WORPD);
      assign drv_val[i] = v;
      assign drv_en[i]  = en & (wand_m ? ~v : (wor_m ? v : 1'b1));
      assign in_val[i]  = lvl_v[i];
      assign low_lvl[i] = (cfg_r[i].isc == ISC_LOW) & ~lvl_v[i] & CE;
      gpx_sense u_sense (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .ce    (CE),
        .pin_v (PIN_IN[i] ^ inv),
        .isc   (cfg_r[i].isc),
        .lvl_v (lvl_v[i]),
        .hit   (hit[i]),
        .wake  (wk[i])
      );
      always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
          pull_en_r[i] <= 1'b0;
          pull_up_r[i] <= 1'b0;
          keep_r[i]    <= 1'b0;
        end else if (CE) begin
          keep_r[i] <= lvl_v[i] ^ inv;
          case (opc)
            OPC_KEEPER: begin
              pull_en_r[i] <= 1'b1;
              pull_up_r[i] <= keep_r[i];
            end
            OPC_PULLDN, OPC_WORPD: begin
              pull_en_r[i] <= 1'b1;
              pull_up_r[i] <= 1'b0;
            end
            OPC_PULLUP, OPC_WANDPU: begin
              pull_en_r[i] <= 1'b1;
              pull_up_r[i] <= 1'b1;
            end
            default: begin
              pull_en_r[i] <= 1'b0;
              pull_up_r[i] <= 1'b0;
            end
          endcase
        end
      end
      // one write may update many pin configs
      always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
          cfg_r[i] <= RST_PINCFG;
        end else if (CE && wr_go && a_cfg && !bad) begin
          if ((mpc_r != 8'h00) ? mpc_r[i] : (cfg_idx == 3'(i))) begin
            cfg_r[i] <= PWDATA[5:0];
          end
        end
      end
    end
  endgenerate

  // software registers
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      dir_r     <= RST_BYTE;
      out_r     <= RST_BYTE;
      intctrl_r <= 4'h0;
      mask0_r   <= RST_BYTE;
      mask1_r   <= RST_BYTE;
      flag_r    <= 2'h0;
      mpc_r     <= RST_BYTE;
      alt_r     <= 5'h00;
    end else if (CE) begin
      dir_r  <= bad ? dir_r : dir_nxt;
      out_r  <= bad ? out_r : out_nxt;
      flag_r <= flag_nxt;
      if (wr_go && !bad && a_ictl) begin
        intctrl_r <= PWDATA[3:0];
      end
      if (wr_go && !bad && a_m0) begin
        mask0_r <= wb;
      end
      if (wr_go && !bad && a_m1) begin
        mask1_r <= wb;
      end
      if (wr_go && !bad && a_alt) begin
        alt_r <= PWDATA[4:0];
      end
      if (wr_go && !bad && a_mpc) begin
        mpc_r <= wb;
      end else if (wr_go && !bad && a_cfg) begin
        mpc_r <= RST_BYTE;
      end
    end
  end

  // bus answer, pins and requests
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      ready_r   <= 1'b0;
      rdata_r   <= RST_WORD;
      err_r     <= 1'b0;
      clkdiv_r  <= 1'b0;
      pout_r    <= RST_BYTE;
      poe_b_r   <= 8'hff;
      altin_r   <= RST_BYTE;
      evt_r     <= RST_BYTE;
      req0_r    <= 1'b0;
      req1_r    <= 1'b0;
    end else if (CE) begin
      ready_r  <= rd_smp;
      rdata_r  <= (rd_smp && !PWRITE && !bad) ? rd_mux : RST_WORD;
      err_r    <= rd_smp & bad;
      clkdiv_r <= ~clkdiv_r;
      pout_r   <= drv_val;
      poe_b_r  <= ~drv_en;
      altin_r  <= in_val;
      evt_r    <= hit;
      req0_r   <= req0_nxt;
      req1_r   <= req1_nxt;
    end
  end

  // wake is kept alive while the port clock is off
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= |(wk & (mask0_r | mask1_r));
    end
  end

  assign PRDATA      = rdata_r;
  assign PREADY      = ready_r;
  assign PSLVERR     = err_r;
  assign PIN_OUT     = pout_r;
  assign PIN_OE_B    = poe_b_r;
  assign PIN_PULL_EN = pull_en_r;
  assign PIN_PULL_UP = pull_up_r;
  assign ALT_IN      = altin_r;
  assign EVT_SENSE   = evt_r;
  assign INT0_REQ    = req0_r;
  assign INT1_REQ    = req1_r;
  assign INT0_LVL    = intctrl_r[1:0];
  assign INT1_LVL    = intctrl_r[3:2];
  assign WAKE        = wake_r;
endmodule

// ===== tb/gpx_monitor.sv
// checker on the port block's APB answer and request outputs
// assumes bind onto gpx_port, one clock domain
`timescale 1ns/1ps
module gpx_monitor
  import gpx_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        CE,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [7:0]  PIN_OE_B,
  input wire logic [7:0]  ALT_EN,
  input wire logic [7:0]  ALT_OE,
  input wire logic        INT0_REQ,
  input wire logic        INT1_REQ,
  input wire logic [1:0]  INT0_LVL,
  input wire logic [1:0]  INT1_LVL
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  AST_RDY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  AST_RDY_TIME: assert property (CE && PSEL && $rose(PENABLE) |=> PREADY) else $error("no ready");
  AST_ERR_RDY: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  AST_RD_IDLE: assert property (!PREADY |-> PRDATA == RST_WORD) else $error("read data outside answer");
  AST_UNALIGNED: assert property (CE && PSEL && PENABLE && !PREADY && PADDR[1:0] != 2'h0 |=> PSLVERR)
    else $error("unaligned access accepted");
  AST_INT0_OFF: assert property (INT0_LVL == LVL_OFF |-> !INT0_REQ) else $error("req0 while off");
  AST_INT1_OFF: assert property (INT1_LVL == LVL_OFF |-> !INT1_REQ) else $error("req1 while off");
  AST_ALT_DRV: assert property (CE && ALT_EN[0] && ALT_OE[0] |=> !PIN_OE_B[0]) else $error("alt not driven");
endmodule

bind gpx_port gpx_monitor u_mon (.CLK_SYS, .RST_B, .CE, .PSEL, .PENABLE, .PADDR, .PRDATA, .PREADY, .PSLVERR,
  .PIN_OE_B, .ALT_EN, .ALT_OE, .INT0_REQ, .INT1_REQ, .INT0_LVL, .INT1_LVL);

// ===== tb/gpx_pins.sv
// board side of the eight pins: bench drivers, pulls, floating lines
// assumes the port drives a pin while its enable is low
`timescale 1ns/1ps
module gpx_pins (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_b,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] last_r = 8'h00;
  wire  [7:0] rel = pin_oe_b & ~ext_en;
  // a floating line flips every cycle
  assign pin_in = (~pin_oe_b & pin_out) | (pin_oe_b & ext_en & ext_val) | (rel & pull_en & pull_up)
    | (rel & ~pull_en & ~last_r);
  always_ff @(posedge clk) last_r <= pin_in;
endmodule

// ===== tb/testbench.sv
// self-checking bench of the port block over APB with a pin model
// assumes gpx_port, gpx_pins and the bound checker are compiled first
`timescale 1ns/1ps
module testbench
  import gpx_pkg::*;
;
  logic        CLK_SYS = 0, RST_B = 0, CE = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, EVT_CH0 = 0;
  logic [7:0]  PADDR = 0, ALT_EN = 0, ALT_OUT = 0, ALT_OE = 0, ext_en = 0, ext_val = 0;
  logic [7:0]  PIN_IN, PIN_OUT, PIN_OE_B, pull_en, pull_up, ALT_IN, EVT_SENSE, m, v, r, dm;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic        PREADY, PSLVERR, INT0_REQ, INT1_REQ, WAKE, err;
  logic [1:0]  INT0_LVL, INT1_LVL;
  int          mismatches = 0, total_checks = 0, seed = 79461, b, k;

  gpx_port uut (.CLK_SYS, .RST_B, .CE, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .PIN_IN, .PIN_OUT, .PIN_OE_B, .PIN_PULL_EN(pull_en), .PIN_PULL_UP(pull_up), .ALT_EN,
    .ALT_OUT, .ALT_OE, .ALT_IN, .EVT_CH0, .EVT_SENSE, .INT0_REQ, .INT1_REQ, .INT0_LVL, .INT1_LVL, .WAKE);
  gpx_pins u_pins (.clk(CLK_SYS), .pin_out(PIN_OUT), .pin_oe_b(PIN_OE_B), .pull_en(pull_en),
    .pull_up(pull_up), .ext_en(ext_en), .ext_val(ext_val), .pin_in(PIN_IN));

  always #4 CLK_SYS = ~CLK_SYS;

  task close_out;
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // one transfer; held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1) @(posedge CLK_SYS);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // plain, set, clear, toggle
  function automatic logic [7:0] upd(input int k, input logic [7:0] o, input logic [7:0] v);
    case (k)
      0: return v;
      1: return o | v;
      2: return o & ~v;
      default: return o ^ v;
    endcase
  endfunction

  initial begin
    #200000;
    mismatches++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge CLK_SYS);
    chk("oe_reset", 32'hff, {24'h0, PIN_OE_B});
    RST_B <= 1'b1;
    CE <= 1'b1;
    for (b = 0; b < 2; b++) begin
      m = 8'h00;
      rdc("reg_reset", b ? OFS_OUT : OFS_DIR, 32'h0);
      for (k = 0; k < 8; k++) begin
        v = 8'($random(seed));
        m = upd(k % 4, m, v);
        wr((b ? OFS_OUT : OFS_DIR) + 8'(4 * (k % 4)), {24'h0, v});
        rdc("dir_out", b ? OFS_OUT : OFS_DIR, {24'h0, m});
      end
      if (b == 0)
        dm = m;
    end
    @(posedge CLK_SYS);
    chk("oe", {24'h0, ~dm}, {24'h0, PIN_OE_B});
    chk("drive", {24'h0, m & dm}, {24'h0, PIN_OUT & ~PIN_OE_B});
    wr(OFS_DIR, 32'hff);
    wr(OFS_OUT, 32'h5a);
    wr(OFS_MPCMASK, 32'hff);
    wr(OFS_PINCFG0, 32'h20);
    rdc("pincfg7", OFS_PINCFG0 + 8'h1c, 32'h20);
    rdc("mpc", OFS_MPCMASK, 32'h0);
    chk("inv_out", 32'ha5, {24'h0, PIN_OUT});
    wr(OFS_DIR, 32'h0);
    r = 8'($random(seed));
    ext_en <= 8'hff;
    ext_val <= r;
    repeat (4) @(posedge CLK_SYS);
    rdc("inv_in", OFS_IN, {24'h0, ~r});
    wr(OFS_BITWIN + 8'h0c, 32'h1);
    rdc("bw_dir", OFS_DIR, 32'h08);
    ext_val <= 8'h01;
    wr(OFS_INTCTRL, 32'hf);
    wr(OFS_INT0MASK, 32'h1);
    for (k = 0; k < 4; k++) begin
      wr(OFS_PINCFG0, 32'(k) << 3);
      repeat (6) @(posedge CLK_SYS);
      wr(OFS_INTFLAGS, 32'h3);
      @(posedge CLK_SYS);
      chk("req_idle", 32'h0, {31'h0, INT0_REQ});
      ext_val <= 8'h00;
      repeat (6) @(posedge CLK_SYS);
      chk("req_fall", 32'(k != ISC_RISE), {31'h0, INT0_REQ});
      chk("req1", 32'h0, {31'h0, INT1_REQ});
      wr(OFS_BITWIN + 8'h60, 32'h1);
      @(posedge CLK_SYS);
      chk("req_low", 32'(k == ISC_LOW), {31'h0, INT0_REQ});
      ext_val <= 8'h01;
      repeat (6) @(posedge CLK_SYS);
      chk("req_rise", 32'(k != ISC_FALL), {31'h0, INT0_REQ});
      wr(OFS_INTFLAGS, 32'h3);
    end
    for (k = 0; k < 3; k++) begin
      v = 8'($random(seed));
      wr(OFS_INTCTRL, {28'h0, v[3:0]});
      @(posedge CLK_SYS);
      chk("lvl", {28'h0, v[3:0]}, {28'h0, INT1_LVL, INT0_LVL});
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
    apb(1'b1, OFS_DIR + 8'h1, 32'hff);
    chk("unaligned", 32'h1, {31'h0, err});
    rdc("dir_kept", OFS_DIR, 32'h08);
    wr(OFS_PINCFG0 + 8'h1c, 32'h0);
    wr(OFS_DIRSET, 32'h80);
    wr(OFS_ALTCTRL, 32'h10);
    for (k = 1; k >= 0; k--) begin
      EVT_CH0 <= k[0];
      repeat (3) @(posedge CLK_SYS);
      chk("evt", 32'(k), {31'h0, PIN_OUT[7]});
    end
    wr(OFS_PINCFG0, 32'h20);
    r = 8'($random(seed));
    ALT_EN <= 8'h01;
    ALT_OE <= 8'h01;
    ALT_OUT <= r;
    repeat (5) @(posedge CLK_SYS);
    chk("alt_out", {31'h0, ~r[0]}, {31'h0, PIN_OUT[0]});
    chk("alt_in", {31'h0, r[0]}, {31'h0, ALT_IN[0]});
    ALT_EN <= 8'h00;
    wr(OFS_PINCFG0, 32'h0);
    wr(OFS_INTFLAGS, 32'h3);
    CE <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    ext_val <= 8'h00;
    // wake is a one-cycle pulse, seen the second edge after the pin falls
    repeat (2) @(posedge CLK_SYS);
    chk("wake", 32'h1, {31'h0, WAKE});
    chk("no_flag", 32'h0, {31'h0, INT0_REQ});
    close_out;
  end
endmodule
